//--- spc_cfg.svh
// offsets, reset values and sizes of the six-pin port control block
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// bus and port sizes
`define SPC_ADDR_W 8
`define SPC_DATA_W 8
`define SPC_PINS 6

// register offsets on the plain register port
`define SPC_OFF_DATA 8'h00
`define SPC_OFF_DIR 8'h01
`define SPC_OFF_PULL 8'h02
`define SPC_OFF_SLEW 8'h03
`define SPC_OFF_DRIVE 8'h04
`define SPC_OFF_PINSEL 8'h05
`define SPC_OFF_EDGE 8'h06

// reset values, all pins quiet inputs
`define SPC_RST_DATA 6'h00
`define SPC_RST_DIR 6'h00
`define SPC_RST_PULL 6'h00
`define SPC_RST_SLEW 6'h00
`define SPC_RST_DRIVE 6'h00
`define SPC_RST_PINSEL 6'h00
`define SPC_RST_EDGE 6'h00

`endif

//--- spc_pkg.sv
// types shared by the six-pin port control block
`default_nettype none
`include "spc_cfg.svh"
package spc_pkg;
   // register selected by a bus address
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_DATA,
      SEL_DIR,
      SEL_PULL,
      SEL_SLEW,
      SEL_DRIVE,
      SEL_PINSEL,
      SEL_EDGE
   } spc_reg_sel_t;

   // one pin's slice of every control register
   typedef struct packed {
      logic dir;
      logic latch;
      logic pull;
      logic slew;
      logic drive;
      logic pinsel;
      logic edge_rise;
   } spc_pin_cfg_t;

   // controls handed to one pad
   typedef struct packed {
      logic oe;
      logic out;
      logic pull_up;
      logic pull_down;
      logic slew;
      logic drive_high;
   } spc_pad_t;
endpackage
`default_nettype wire

//--- spc_ctl_reg.sv
// one software-written control register with reset value
`timescale 1ns/1ps
`default_nettype none
module spc_ctl_reg #(
   parameter int W = 6,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_we,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] next_q;

   // load on write strobe, hold otherwise
   always_comb begin
      next_q = i_we ? i_d : o_q;
   end

   // register with asynchronous clear to reset value
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_q <= RST;
      end else begin
         o_q <= next_q;
      end
   end
endmodule
`default_nettype wire

//--- spc_pin_cell.sv
// pad control for one port pin
`timescale 1ns/1ps
`default_nettype none
module spc_pin_cell (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire spc_pkg::spc_pin_cfg_t i_cfg,
   output spc_pkg::spc_pad_t o_pad
);
   spc_pkg::spc_pad_t next_pad;

   // pad controls from the pin's register bits
   always_comb begin
      next_pad.oe = i_cfg.dir;
      next_pad.out = i_cfg.dir & i_cfg.latch;
      // pulls only on inputs; pull-down only with pin and edge select
      next_pad.pull_up = ~i_cfg.dir & i_cfg.pull
         & ~(i_cfg.pinsel & i_cfg.edge_rise);
      next_pad.pull_down = ~i_cfg.dir & i_cfg.pull
         & i_cfg.pinsel & i_cfg.edge_rise;
      next_pad.slew = i_cfg.dir & i_cfg.slew;
      next_pad.drive_high = i_cfg.dir & i_cfg.drive;
   end

   // registered pad controls, all quiet in reset
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pad <= '0;
      end else begin
         o_pad <= next_pad;
      end
   end
endmodule
`default_nettype wire

//--- spc_port.sv
// six-pin port: control registers, read path and pad controls
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
// Summary of operation
// - direction 0: driver off, read shows pin
// - direction 1: driver on, read shows latch
// - pull bit 1 enables pull-up on input unless pin and edge select are both set
// - output pins ignore pull bit, pulls off
// - pull-down only with pin and edge select
// - slew bit limits slew, inputs unaffected
// - drive bit picks low/high drive, outputs only
// - direction bits readable and writable per pin
// - data writes latch; latch drives output pins
// - reset clears latch, pins quiet inputs
module spc_port #(
   parameter int PINS = `SPC_PINS,
   parameter int DATA_W = `SPC_DATA_W,
   parameter int ADDR_W = `SPC_ADDR_W
) (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [DATA_W-1:0] O_RDATA,
   input wire logic [PINS-1:0] I_PIN_IN,
   output logic [PINS-1:0] O_PIN_OUT,
   output logic [PINS-1:0] O_PIN_OE,
   output logic [PINS-1:0] O_PULL_UP,
   output logic [PINS-1:0] O_PULL_DOWN,
   output logic [PINS-1:0] O_SLEW,
   output logic [PINS-1:0] O_DRIVE_HIGH
);
   spc_pkg::spc_reg_sel_t sel;
   logic [PINS-1:0] wdata_pins;
   logic [PINS-1:0] port_data_latch;
   logic [PINS-1:0] port_direction_bits;
   logic [PINS-1:0] port_pullup_enable_bits;
   logic [PINS-1:0] port_slew_enable_bits;
   logic [PINS-1:0] port_drive_strength_bits;
   logic [PINS-1:0] port_pin_select_bits;
   logic [PINS-1:0] port_edge_select_bits;
   logic [PINS-1:0] pin_view;
   logic [PINS-1:0] read_pins;
   logic [DATA_W-1:0] next_rdata;
   spc_pkg::spc_pad_t pad [PINS];

   // address decode to a register select
   always_comb begin
      unique case (I_ADDR)
         `SPC_OFF_DATA: sel = spc_pkg::SEL_DATA;
         `SPC_OFF_DIR: sel = spc_pkg::SEL_DIR;
         `SPC_OFF_PULL: sel = spc_pkg::SEL_PULL;
         `SPC_OFF_SLEW: sel = spc_pkg::SEL_SLEW;
         `SPC_OFF_DRIVE: sel = spc_pkg::SEL_DRIVE;
         `SPC_OFF_PINSEL: sel = spc_pkg::SEL_PINSEL;
         `SPC_OFF_EDGE: sel = spc_pkg::SEL_EDGE;
         default: sel = spc_pkg::SEL_NONE;
      endcase
   end

   // only the six pin bits are stored, upper bits dropped
   assign wdata_pins = I_WDATA[PINS-1:0];

   // port data latch, cleared by reset
   spc_ctl_reg #(.W(PINS), .RST(`SPC_RST_DATA)) u_data (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_we(I_WR && sel == spc_pkg::SEL_DATA),
      .i_d(wdata_pins),
      .o_q(port_data_latch)
   );

   // direction bits, all inputs after reset
   spc_ctl_reg #(.W(PINS), .RST(`SPC_RST_DIR)) u_dir (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_we(I_WR && sel == spc_pkg::SEL_DIR),
      .i_d(wdata_pins),
      .o_q(port_direction_bits)
   );

   // pull enable bits, pulls off after reset
   spc_ctl_reg #(.W(PINS), .RST(`SPC_RST_PULL)) u_pull (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_we(I_WR && sel == spc_pkg::SEL_PULL),
      .i_d(wdata_pins),
      .o_q(port_pullup_enable_bits)
   );

   // slew enable bits; software sets these at start-up
   spc_ctl_reg #(.W(PINS), .RST(`SPC_RST_SLEW)) u_slew (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_we(I_WR && sel == spc_pkg::SEL_SLEW),
      .i_d(wdata_pins),
      .o_q(port_slew_enable_bits)
   );

   // drive strength bits
   spc_ctl_reg #(.W(PINS), .RST(`SPC_RST_DRIVE)) u_drive (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_we(I_WR && sel == spc_pkg::SEL_DRIVE),
      .i_d(wdata_pins),
      .o_q(port_drive_strength_bits)
   );

   // pin interrupt pin-select bits, steer the pull-down
   spc_ctl_reg #(.W(PINS), .RST(`SPC_RST_PINSEL)) u_pinsel (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_we(I_WR && sel == spc_pkg::SEL_PINSEL),
      .i_d(wdata_pins),
      .o_q(port_pin_select_bits)
   );

   // pin interrupt edge-select bits, 1 means rising edge
   spc_ctl_reg #(.W(PINS), .RST(`SPC_RST_EDGE)) u_edge (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_we(I_WR && sel == spc_pkg::SEL_EDGE),
      .i_d(wdata_pins),
      .o_q(port_edge_select_bits)
   );

   // one pad control cell per pin
   generate
      for (genvar i = 0; i < PINS; i++) begin : g_pin
         spc_pkg::spc_pin_cfg_t cfg;
         always_comb begin
            cfg.dir = port_direction_bits[i];
            cfg.latch = port_data_latch[i];
            cfg.pull = port_pullup_enable_bits[i];
            cfg.slew = port_slew_enable_bits[i];
            cfg.drive = port_drive_strength_bits[i];
            cfg.pinsel = port_pin_select_bits[i];
            cfg.edge_rise = port_edge_select_bits[i];
         end
         spc_pin_cell u_cell (
            .i_clk(I_CLK),
            .i_reset_n(I_RESET_N),
            .i_cfg(cfg),
            .o_pad(pad[i])
         );
         assign O_PIN_OE[i] = pad[i].oe;
         assign O_PIN_OUT[i] = pad[i].out;
         assign O_PULL_UP[i] = pad[i].pull_up;
         assign O_PULL_DOWN[i] = pad[i].pull_down;
         assign O_SLEW[i] = pad[i].slew;
         assign O_DRIVE_HIGH[i] = pad[i].drive_high;
      end
   endgenerate

   // data read view: latch for outputs, live level for inputs
   assign pin_view = (port_direction_bits & port_data_latch)
      | (~port_direction_bits & I_PIN_IN);

   // register contents for the addressed read
   always_comb begin
      read_pins = '0;
      unique case (sel)
         spc_pkg::SEL_DATA: read_pins = pin_view;
         spc_pkg::SEL_DIR: read_pins = port_direction_bits;
         spc_pkg::SEL_PULL: read_pins = port_pullup_enable_bits;
         spc_pkg::SEL_SLEW: read_pins = port_slew_enable_bits;
         spc_pkg::SEL_DRIVE: read_pins = port_drive_strength_bits;
         spc_pkg::SEL_PINSEL: read_pins = port_pin_select_bits;
         spc_pkg::SEL_EDGE: read_pins = port_edge_select_bits;
         spc_pkg::SEL_NONE: read_pins = '0;
      endcase
   end

   // read data valid in the cycle after the strobe only
   always_comb begin
      next_rdata = '0;
      if (I_RD) begin
         next_rdata = {{(DATA_W-PINS){1'b0}}, read_pins};
      end
   end

   // read data register
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_RDATA <= '0;
      end else begin
         O_RDATA <= next_rdata;
      end
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESET_N);

   // direction write reaches the drivers two cycles on
   property p_dir_to_oe;
      logic [PINS-1:0] v;
      (I_WR && I_ADDR == `SPC_OFF_DIR, v = I_WDATA[PINS-1:0]) ##1 !I_WR
         |=> O_PIN_OE == v;
   endproperty
   a_dir_drives_oe: assert property (p_dir_to_oe)
      else $error("driver enables differ from written direction");

   // data reads: live pin for inputs, latch for outputs
   a_read_pin_src: assert property (
      I_RD && I_ADDR == `SPC_OFF_DATA |=> O_RDATA[PINS-1:0] ==
         (($past(port_direction_bits) & $past(port_data_latch))
         | (~$past(port_direction_bits) & $past(I_PIN_IN))))
      else $error("data read returned wrong source");

   // enabled driver means direction was output one cycle before
   a_oe_follows_dir: assert property (
      O_PIN_OE == $past(port_direction_bits))
      else $error("driver enable not following direction");

   // latched data goes out on output pins only
   property p_latch_out;
      logic [PINS-1:0] v;
      (I_WR && I_ADDR == `SPC_OFF_DATA, v = I_WDATA[PINS-1:0]) ##1 !I_WR
         |=> O_PIN_OUT == (v & O_PIN_OE);
   endproperty
   a_latch_drives_pin: assert property (p_latch_out)
      else $error("latched data not driven on output pins");

   // pull-up follows the enable on plain inputs
   a_pullup_input: assert property (
      O_PULL_UP == $past(port_pullup_enable_bits & ~port_direction_bits
         & ~(port_pin_select_bits & port_edge_select_bits)))
      else $error("pull-up does not follow its enable");

   // no pull device on a driven pin
   a_pull_off_output: assert property (
      ((O_PULL_UP | O_PULL_DOWN) & O_PIN_OE) == '0)
      else $error("pull device active on an output");

   // pull-down needs pin select, edge select and pull enable
   a_pulldown_gate: assert property (
      (O_PULL_DOWN & ~$past(port_pin_select_bits & port_edge_select_bits
         & port_pullup_enable_bits)) == '0)
      else $error("pull-down without interrupt configuration");

   // slew limiting never on an input
   a_slew_input: assert property (
      (O_SLEW & ~O_PIN_OE) == '0)
      else $error("slew control active on an input");

   // drive write: 1 high, 0 low, outputs only
   property p_drive_sel;
      logic [PINS-1:0] v;
      (I_WR && I_ADDR == `SPC_OFF_DRIVE, v = I_WDATA[PINS-1:0]) ##1 !I_WR
         |=> O_DRIVE_HIGH == (v & O_PIN_OE);
   endproperty
   a_drive_select: assert property (p_drive_sel)
      else $error("drive strength not as written");

   // upper read bits always zero
   a_upper_zero: assert property (
      O_RDATA[DATA_W-1:PINS] == '0)
      else $error("unimplemented bits read non-zero");

   // no output value on a pin whose driver is off
   a_out_quiet_input: assert property (
      (O_PIN_OUT & ~O_PIN_OE) == '0)
      else $error("output value on an input pin");

   // drive strength never raised on an input
   a_drive_input: assert property (
      (O_DRIVE_HIGH & ~O_PIN_OE) == '0)
      else $error("high drive active on an input");

   // read data stands one cycle only, zero otherwise
   a_rdata_idle: assert property (
      !I_RD |=> O_RDATA == '0)
      else $error("read data present without a read");

   // direction bits read back as stored
   a_dir_readback: assert property (
      I_RD && I_ADDR == `SPC_OFF_DIR
         |=> O_RDATA[PINS-1:0] == $past(port_direction_bits))
      else $error("direction read differs from stored bits");

   // unmapped addresses read zero
   a_unmapped_read: assert property (
      I_RD && I_ADDR > `SPC_OFF_EDGE |=> O_RDATA == '0)
      else $error("unmapped address read non-zero");

   // reset holds latch clear and pins quiet inputs
   a_reset_quiet: assert property (disable iff (1'b0)
      !I_RESET_N |-> (port_data_latch == '0 && O_PIN_OE == '0
         && O_PULL_UP == '0 && O_PULL_DOWN == '0))
      else $error("reset did not quiet the port");

   // main scenarios
   c_output_read: cover property (
      I_RD && I_ADDR == `SPC_OFF_DATA && port_direction_bits != '0);
   c_input_read: cover property (
      I_RD && I_ADDR == `SPC_OFF_DATA && port_direction_bits == '0);
   c_pulldown: cover property (O_PULL_DOWN != '0);
   c_unmapped_read: cover property (I_RD && I_ADDR > `SPC_OFF_EDGE);
   c_drive_high: cover property (O_DRIVE_HIGH != '0 && O_SLEW != '0);
endmodule
`default_nettype wire

//--- spc_pin_model.sv
// outside world at the six port pins: pads, an outside driver, pulls
`timescale 1ns/1ps
`default_nettype none
module spc_pin_model (
   input wire logic i_clk,
   input wire logic [5:0] i_oe,
   input wire logic [5:0] i_out,
   input wire logic [5:0] i_pu,
   input wire logic [5:0] i_pd,
   input wire logic [5:0] i_ext_en,
   input wire logic [5:0] i_ext_val,
   output logic [5:0] o_pin
);
   logic flt = 1'b0;
   // undriven, unpulled pins wander every cycle
   always @(posedge i_clk) begin
      flt <= ~flt;
   end
   // pin level: pad driver first, then outside driver, then pulls
   assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
      | (~i_oe & ~i_ext_en & (i_pu | (~i_pd & {6{flt}})));
endmodule
`default_nettype wire

//--- tb_spc_port.sv
// self-checking bench for the six-pin port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   $display("BAD %s exp %h got %h", nm, e, g); n_mismatch++; end end
module tb_spc_port;
   logic clk, reset_n, wr_s, rd_s;
   logic [7:0] addr, wdata, rdata;
   logic [5:0] pin, p_out, p_oe, p_pu, p_pd, p_sl, p_dh, ext_en, ext_val;
   int n_mismatch = 0;
   int n_checks = 0;

   spc_port i_dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
      .I_PIN_IN(pin), .O_PIN_OUT(p_out), .O_PIN_OE(p_oe),
      .O_PULL_UP(p_pu), .O_PULL_DOWN(p_pd), .O_SLEW(p_sl),
      .O_DRIVE_HIGH(p_dh));
   spc_pin_model i_pins (.i_clk(clk), .i_oe(p_oe), .i_out(p_out),
      .i_pu(p_pu), .i_pd(p_pd), .i_ext_en(ext_en), .i_ext_val(ext_val),
      .o_pin(pin));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask

   // pads settle two cycles after the write: oe,out,pu,pd,slew,drive
   task automatic chk_pads(input logic [35:0] e);
      repeat (2) @(posedge clk);
      #1;
      `CHK("pads", e, {p_oe, p_out, p_pu, p_pd, p_sl, p_dh})
   endtask

   task automatic drive_ext(input logic [5:0] en, input logic [5:0] v);
      @(posedge clk);
      ext_en <= en;
      ext_val <= v;
   endtask

   task automatic test_reset;
      chk_pads(36'h0);
      for (int k = 0; k < 7; k++) begin
         chk_rd(8'(k), 8'h00);
      end
      $display("test reset done");
   endtask

   task automatic test_regs;
      for (int k = 1; k < 7; k++) begin
         wr(8'(k), 8'hFF);
         chk_rd(8'(k), 8'h3F);
         wr(8'(k), 8'h00);
         chk_rd(8'(k), 8'h00);
      end
      wr(8'h07, 8'hFF);
      chk_rd(8'h07, 8'h00);
      chk_pads(36'h0);
      $display("test regs done");
   endtask

   task automatic test_dir;
      drive_ext(6'h30, 6'h15);
      wr(8'h00, 8'hEA);
      wr(8'h01, 8'h0F);
      chk_pads({6'h0F, 6'h0A, 6'h00, 6'h00, 6'h00, 6'h00});
      chk_rd(8'h00, 8'h1A);
      chk_rd(8'h01, 8'h0F);
      $display("test dir done");
   endtask

   task automatic test_pull;
      drive_ext(6'h00, 6'h00);
      wr(8'h02, 8'h3F);
      chk_pads({6'h0F, 6'h0A, 6'h30, 6'h00, 6'h00, 6'h00});
      wr(8'h05, 8'h3F);
      wr(8'h06, 8'h10);
      chk_pads({6'h0F, 6'h0A, 6'h20, 6'h10, 6'h00, 6'h00});
      chk_rd(8'h00, 8'h2A);
      $display("test pull done");
   endtask

   task automatic test_drive;
      wr(8'h03, 8'h3C);
      wr(8'h04, 8'h33);
      chk_pads({6'h0F, 6'h0A, 6'h20, 6'h10, 6'h0C, 6'h03});
      wr(8'h01, 8'h3F);
      chk_pads({6'h3F, 6'h2A, 6'h00, 6'h00, 6'h3C, 6'h33});
      chk_rd(8'h00, 8'h2A);
      $display("test drive done");
   endtask

   task automatic test_rerun_reset;
      @(posedge clk);
      reset_n <= 1'b0;
      chk_pads(36'h0);
      @(posedge clk);
      reset_n <= 1'b1;
      drive_ext(6'h3F, 6'h3F);
      chk_rd(8'h01, 8'h00);
      chk_rd(8'h00, 8'h3F);
      wr(8'h01, 8'h3F);
      chk_rd(8'h00, 8'h00);
      $display("test rerun reset done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      clk = 1'b0;
      reset_n = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      ext_en = 6'h3F;
      ext_val = 6'h00;
      // reset falls just after time zero so the clear edge is seen
      #1;
      reset_n = 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      test_reset();
      test_regs();
      test_dir();
      test_pull();
      test_drive();
      test_rerun_reset();
      conclude();
   end

   // watchdog well beyond the roughly 120 cycles the tests need
   initial begin
      #75000;
      n_mismatch++;
      conclude();
   end
endmodule
`default_nettype wire
